// *** hdl/ccp_pkg.sv ***
package ccp_pkg;
	localparam int          LATCH_N      = 4;
	localparam int          BYTE_BITS    = 8;
	localparam logic [2:0]  LAST_BIT     = 3'h7;
	// Byte 1 field positions
	localparam int          B1_POWER     = 7;
	localparam int          B1_CODE_HI   = 6;
	localparam int          B1_CODE_LO   = 3;
	localparam int          B1_READ      = 2;
	localparam int          B1_TWO       = 1;
	// Register codes
	localparam logic [3:0]  CODE_CTRL    = 4'h0;
	localparam logic [3:0]  CODE_LDATA   = 4'h1;
	localparam logic [3:0]  CODE_LDIR    = 4'h2;
	localparam logic [3:0]  CODE_RX_GAIN = 4'h4;
	localparam logic [3:0]  CODE_TX_GAIN = 4'h5;
	// Control register fields
	localparam int          CTRL_LAW     = 5;
	localparam int          CTRL_DELAY   = 3;
	// Reset values
	localparam logic [7:0]  CTRL_RST     = 8'h00;
	localparam logic [7:0]  GAIN_RST     = 8'h00;
	localparam logic [3:0]  LDIR_RST     = 4'h0;
	localparam logic [3:0]  LDATA_RST    = 4'h0;
	localparam logic        POWER_UP     = 1'b0;
	localparam logic        POWER_DOWN   = 1'b1;
	// Controller registers, byte addresses on Avalon-MM
	localparam logic [3:0]  HREG_CMD     = 4'h0;
	localparam logic [3:0]  HREG_STATUS  = 4'h4;
	localparam logic [3:0]  HREG_PCM     = 4'h8;
	// Timing
	localparam int          CLK_NS       = 5;
	localparam int          CONTROL_CLOCK_HALF_NS = 40;
	localparam int          BCLK_HALF_NS = 40;
	localparam int          CONTROL_CLOCK_HALF    = CONTROL_CLOCK_HALF_NS / CLK_NS;
	localparam int          BCLK_HALF    = BCLK_HALF_NS / CLK_NS;
	localparam int          FRAME_BITS   = 32;

	function automatic logic code_valid(input logic [3:0] code);
		code_valid = (code == CODE_CTRL) || (code == CODE_LDATA) || (code == CODE_LDIR) ||
			(code == CODE_RX_GAIN) || (code == CODE_TX_GAIN);
	endfunction
endpackage

// *** hdl/ccp_if.sv ***
`timescale 1ns/1ps
interface ccp_if;
	logic control_clock;
	logic chip_select_n;
	logic control_data_in;
	logic control_data_out;
	logic control_data_out_oe_n;
	logic bit_clock;
	logic frame_sync_tx;
	logic frame_sync_rx;
	logic pcm_tx_out;
	logic pcm_tx_oe_n;
	logic pcm_rx_in;
	// Undriven lines are pulled high
	wire  control_data_out_line = control_data_out_oe_n ? 1'b1 : control_data_out;
	wire  pcm_tx_line           = pcm_tx_oe_n ? 1'b1 : pcm_tx_out;

	modport dev (input control_clock, chip_select_n, control_data_in, bit_clock, frame_sync_tx,
		frame_sync_rx, pcm_rx_in, output control_data_out, control_data_out_oe_n, pcm_tx_out, pcm_tx_oe_n);
	modport host (output control_clock, chip_select_n, control_data_in, bit_clock, frame_sync_tx,
		frame_sync_rx, pcm_rx_in, input control_data_out_line, pcm_tx_line);
endinterface

// *** hdl/ccp_sync.sv ***
`timescale 1ns/1ps
module ccp_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	always_comb
	begin
		meta_d = d_i;
		q_d    = meta_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			meta_q <= RST;
			q_o    <= RST;
		end
		else
		begin
			meta_q <= meta_d;
			q_o    <= q_d;
		end
	end
endmodule

// *** hdl/ccp_device.sv ***
// Overview of operation
// - Control transfers only while chip select low
// - Direction bit picks input or output per latch
// - Input latch levels captured at the end of every byte 1
// - Output latches drive last written data bit
// - Power-on reset enters powered-down state
// - Reset: gains zero, amp off, non-delayed timing
// - Reset: all latch pins inputs, undriven
// - Control data output undriven after reset
// - Programming accepted while powered down
// - Valid instruction power bit one powers down
// - Host should power down before reprogramming
// - Powered down: transmit PCM output undriven
// - Powered down: registers kept, port active
// - Powered down: latch pins keep working
// - Encode cycle starts after transmit slot ends
// - Transmit byte shifted on eight rising edges
// - Receive byte sampled on eight falling edges
// - One law selection for encoder and decoder
// - Byte 1: power, code, read, two-byte bits
// - Bit 7 shifted first in every byte
// - Eight clocks per byte, sample fall, drive rise
// - Mid-byte chip select rise clears bit count, back to byte 1
// - Power bit zero up, one down
`timescale 1ns/1ps
module ccp_device #(
	parameter int LATCH_N = ccp_pkg::LATCH_N
) (
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	ccp_if.dev                      bus,
	input  wire logic [LATCH_N-1:0] latch_pins_i,
	output logic      [LATCH_N-1:0] latch_pins_o,
	output logic      [LATCH_N-1:0] latch_pins_oe_n_o,
	input  wire logic [7:0]         tx_pcm_i,
	output logic      [7:0]         rx_pcm_o,
	output logic                    rx_pcm_valid_o,
	output logic                    encode_start_o,
	output logic                    power_down_o,
	output logic                    law_sel_o,
	output logic                    delayed_timing_o,
	output logic      [7:0]         rx_gain_o,
	output logic      [7:0]         tx_gain_o
);
	typedef enum logic [1:0] {ST_B1, ST_WR, ST_RD} ccp_dst_t;

	localparam int SW = 7 + LATCH_N;
	logic [SW-1:0]      sync_s;
	logic               control_clock_s, cs_n_s, ci_s, bclk_s, fsx_s, fsr_s, rx_s;
	logic [LATCH_N-1:0] pins_s;

	// Every pin is resynchronised; chip select idles high
	ccp_sync #(.W(SW), .RST({1'b0, 1'b1, {(SW-2){1'b0}}})) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.d_i       ({bus.control_clock, bus.chip_select_n, bus.control_data_in, bus.bit_clock,
			bus.frame_sync_tx, bus.frame_sync_rx, bus.pcm_rx_in, latch_pins_i}),
		.q_o       (sync_s)
	);
	assign {control_clock_s, cs_n_s, ci_s, bclk_s, fsx_s, fsr_s, rx_s, pins_s} = sync_s;

	// Control port state
	ccp_dst_t           st_q, st_d;
	logic [2:0]         bit_q, bit_d;
	logic [7:0]         sh_q, sh_d, out_q, out_d;
	logic [3:0]         code_q, code_d;
	logic               control_clock_p_q, control_clock_p_d, co_q, co_d, co_oe_n_q, co_oe_n_d, pd_q, pd_d;
	logic [7:0]         ctrl_q, ctrl_d, rxg_q, rxg_d, txg_q, txg_d;
	logic [LATCH_N-1:0] ldata_q, ldata_d, loe_n_q, loe_n_d;
	logic [LATCH_N-1:0] cap_v;
	logic [7:0]         byte_v, rd_v;
	logic [3:0]         code_v;
	logic               c_rise, c_fall;

	always_comb
	begin
		st_d      = st_q;
		bit_d     = bit_q;
		sh_d      = sh_q;
		out_d     = out_q;
		code_d    = code_q;
		co_d      = co_q;
		co_oe_n_d = co_oe_n_q;
		pd_d      = pd_q;
		ctrl_d    = ctrl_q;
		rxg_d     = rxg_q;
		txg_d     = txg_q;
		ldata_d   = ldata_q;
		loe_n_d   = loe_n_q;
		control_clock_p_d  = control_clock_s;
		c_rise    = control_clock_s & ~control_clock_p_q;
		c_fall    = ~control_clock_s & control_clock_p_q;
		byte_v    = {sh_q[6:0], ci_s};
		code_v    = byte_v[ccp_pkg::B1_CODE_HI:ccp_pkg::B1_CODE_LO];
		for (int i = 0; i < LATCH_N; i++)
			cap_v[i] = loe_n_q[i] ? pins_s[i] : ldata_q[i];
		case (code_v)
			ccp_pkg::CODE_CTRL:    rd_v = ctrl_q;
			ccp_pkg::CODE_LDATA:   rd_v = 8'(cap_v);
			ccp_pkg::CODE_LDIR:    rd_v = {{(8 - LATCH_N){1'b0}}, ~loe_n_q};
			ccp_pkg::CODE_RX_GAIN: rd_v = rxg_q;
			ccp_pkg::CODE_TX_GAIN: rd_v = txg_q;
			default:               rd_v = 8'h00;
		endcase
		if (cs_n_s)
		begin
			// Abandon a partial byte; a finished byte 1 may await a new select for byte 2
			co_oe_n_d = 1'b1;
			bit_d     = 3'h0;
			if (bit_q != 3'h0)
				st_d = ST_B1;
		end
		else
		begin
			if (st_q == ST_RD && c_rise)
			begin
				co_d      = out_q[7];
				out_d     = {out_q[6:0], 1'b0};
				co_oe_n_d = 1'b0;
			end
			if (c_fall)
			begin
				sh_d  = byte_v;
				bit_d = bit_q + 3'h1;
				if (bit_q == ccp_pkg::LAST_BIT)
				begin
					case (st_q)
						ST_B1:
						begin
							ldata_d = cap_v;
							if (!byte_v[ccp_pkg::B1_TWO])
								pd_d = byte_v[ccp_pkg::B1_POWER];
							else
							begin
								// Invalid codes still consume byte 2 so framing stays aligned
								if (ccp_pkg::code_valid(code_v))
									pd_d = byte_v[ccp_pkg::B1_POWER];
								code_d = code_v;
								out_d  = rd_v;
								st_d   = byte_v[ccp_pkg::B1_READ] ? ST_RD : ST_WR;
							end
						end
						ST_WR:
						begin
							// Writes land regardless of power state
							case (code_q)
								ccp_pkg::CODE_CTRL:    ctrl_d  = byte_v;
								ccp_pkg::CODE_LDATA:   ldata_d = byte_v[LATCH_N-1:0];
								ccp_pkg::CODE_LDIR:    loe_n_d = ~byte_v[LATCH_N-1:0];
								ccp_pkg::CODE_RX_GAIN: rxg_d   = byte_v;
								ccp_pkg::CODE_TX_GAIN: txg_d   = byte_v;
								default:               ;
							endcase
							st_d = ST_B1;
						end
						default:
						begin
							co_oe_n_d = 1'b1;
							st_d      = ST_B1;
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			st_q      <= ST_B1;
			bit_q     <= 3'h0;
			sh_q      <= 8'h00;
			out_q     <= 8'h00;
			code_q    <= ccp_pkg::CODE_CTRL;
			control_clock_p_q  <= 1'b0;
			co_q      <= 1'b0;
			co_oe_n_q <= 1'b1;
			pd_q      <= ccp_pkg::POWER_DOWN;
			ctrl_q    <= ccp_pkg::CTRL_RST;
			rxg_q     <= ccp_pkg::GAIN_RST;
			txg_q     <= ccp_pkg::GAIN_RST;
			ldata_q   <= LATCH_N'(ccp_pkg::LDATA_RST);
			loe_n_q   <= ~LATCH_N'(ccp_pkg::LDIR_RST);
		end
		else
		begin
			st_q      <= st_d;
			bit_q     <= bit_d;
			sh_q      <= sh_d;
			out_q     <= out_d;
			code_q    <= code_d;
			control_clock_p_q  <= control_clock_p_d;
			co_q      <= co_d;
			co_oe_n_q <= co_oe_n_d;
			pd_q      <= pd_d;
			ctrl_q    <= ctrl_d;
			rxg_q     <= rxg_d;
			txg_q     <= txg_d;
			ldata_q   <= ldata_d;
			loe_n_q   <= loe_n_d;
		end
	end

	// PCM side; only non-delayed timing is modelled, slots start at frame sync rise
	logic       bclk_p_q, bclk_p_d, fsx_p_q, fsx_p_d, fsr_p_q, fsr_p_d;
	logic       dx_q, dx_d, dx_oe_n_q, dx_oe_n_d, enc_q, enc_d, rxv_q, rxv_d;
	logic [3:0] txc_q, txc_d, rxc_q, rxc_d;
	logic [7:0] txsh_q, txsh_d, txb_q, txb_d, rxsh_q, rxsh_d, rxb_q, rxb_d;
	logic       b_rise, b_fall;

	always_comb
	begin
		bclk_p_d  = bclk_s;
		fsx_p_d   = fsx_p_q;
		fsr_p_d   = fsr_p_q;
		dx_d      = dx_q;
		dx_oe_n_d = dx_oe_n_q;
		enc_d     = 1'b0;
		rxv_d     = 1'b0;
		txc_d     = txc_q;
		rxc_d     = rxc_q;
		txsh_d    = txsh_q;
		txb_d     = txb_q;
		rxsh_d    = rxsh_q;
		rxb_d     = rxb_q;
		b_rise    = bclk_s & ~bclk_p_q;
		b_fall    = ~bclk_s & bclk_p_q;
		if (b_rise)
		begin
			fsx_p_d = fsx_s;
			fsr_p_d = fsr_s;
			if (fsx_s && !fsx_p_q)
			begin
				dx_d      = txb_q[7];
				txsh_d    = {txb_q[6:0], 1'b0};
				txc_d     = 4'(ccp_pkg::BYTE_BITS - 1);
				dx_oe_n_d = 1'b0;
			end
			else if (txc_q != 4'h0)
			begin
				dx_d   = txsh_q[7];
				txsh_d = {txsh_q[6:0], 1'b0};
				txc_d  = txc_q - 4'h1;
			end
			else if (!dx_oe_n_q)
			begin
				dx_oe_n_d = 1'b1;
				enc_d     = 1'b1;
				txb_d     = tx_pcm_i;
			end
			if (fsr_s && !fsr_p_q && !pd_q)
				rxc_d = 4'(ccp_pkg::BYTE_BITS);
		end
		if (b_fall && rxc_q != 4'h0)
		begin
			rxsh_d = {rxsh_q[6:0], rx_s};
			rxc_d  = rxc_q - 4'h1;
			if (rxc_q == 4'h1)
			begin
				rxb_d = {rxsh_q[6:0], rx_s};
				rxv_d = 1'b1;
			end
		end
		if (pd_q)
		begin
			dx_oe_n_d = 1'b1;
			txc_d     = 4'h0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			bclk_p_q  <= 1'b0;
			fsx_p_q   <= 1'b0;
			fsr_p_q   <= 1'b0;
			dx_q      <= 1'b0;
			dx_oe_n_q <= 1'b1;
			enc_q     <= 1'b0;
			rxv_q     <= 1'b0;
			txc_q     <= 4'h0;
			rxc_q     <= 4'h0;
			txsh_q    <= 8'h00;
			txb_q     <= 8'h00;
			rxsh_q    <= 8'h00;
			rxb_q     <= 8'h00;
		end
		else
		begin
			bclk_p_q  <= bclk_p_d;
			fsx_p_q   <= fsx_p_d;
			fsr_p_q   <= fsr_p_d;
			dx_q      <= dx_d;
			dx_oe_n_q <= dx_oe_n_d;
			enc_q     <= enc_d;
			rxv_q     <= rxv_d;
			txc_q     <= txc_d;
			rxc_q     <= rxc_d;
			txsh_q    <= txsh_d;
			txb_q     <= txb_d;
			rxsh_q    <= rxsh_d;
			rxb_q     <= rxb_d;
		end
	end

	assign bus.control_data_out      = co_q;
	assign bus.control_data_out_oe_n = co_oe_n_q;
	assign bus.pcm_tx_out            = dx_q;
	assign bus.pcm_tx_oe_n           = dx_oe_n_q;
	assign latch_pins_o              = ldata_q;
	assign latch_pins_oe_n_o         = loe_n_q;
	assign rx_pcm_o                  = rxb_q;
	assign rx_pcm_valid_o            = rxv_q;
	assign encode_start_o            = enc_q;
	assign power_down_o              = pd_q;
	assign law_sel_o                 = ctrl_q[ccp_pkg::CTRL_LAW];
	assign delayed_timing_o          = ctrl_q[ccp_pkg::CTRL_DELAY];
	assign rx_gain_o                 = rxg_q;
	assign tx_gain_o                 = txg_q;
endmodule

// *** hdl/ccp_host.sv ***
`timescale 1ns/1ps
module ccp_host #(
	parameter int CONTROL_CLOCK_HALF  = ccp_pkg::CONTROL_CLOCK_HALF,
	parameter int BCLK_HALF  = ccp_pkg::BCLK_HALF,
	parameter int FRAME_BITS = ccp_pkg::FRAME_BITS
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	ccp_if.host              bus,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o
);
	typedef enum logic [1:0] {H_IDLE, H_HI, H_LO, H_END} ccp_hst_t;
	localparam int IW = $clog2(FRAME_BITS);

	logic co_s, dx_s;
	ccp_sync #(.W(2), .RST(2'h3)) u_sync (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.d_i       ({bus.control_data_out_line, bus.pcm_tx_line}),
		.q_o       ({co_s, dx_s})
	);

	ccp_hst_t    st_q, st_d;
	logic [7:0]  div_q, div_d, rx_q, rx_d, pcm_out_q, pcm_out_d, cap_q;
	logic [15:0] tx_q, tx_d;
	logic [4:0]  left_q, left_d;
	logic        cs_n_q, cs_n_d, control_clock_q, control_clock_d, ci_q, ci_d, wreq_q, wreq_d;
	logic [31:0] rdata_q, rdata_d;
	logic        req, take, tick;

	always_comb
	begin
		st_d      = st_q;
		div_d     = div_q + 8'h01;
		rx_d      = rx_q;
		tx_d      = tx_q;
		left_d    = left_q;
		cs_n_d    = cs_n_q;
		control_clock_d    = control_clock_q;
		ci_d      = ci_q;
		pcm_out_d = pcm_out_q;
		rdata_d   = rdata_q;
		req       = avs_read_i | avs_write_i;
		take      = req & ~wreq_q;
		tick      = div_q == 8'(CONTROL_CLOCK_HALF - 1);
		// One wait cycle, then a single-cycle acknowledge
		wreq_d    = ~(req & wreq_q);
		if (req && wreq_q)
		begin
			case (avs_address_i)
				ccp_pkg::HREG_STATUS: rdata_d = {16'h0000, rx_q, 7'h00, st_q != H_IDLE};
				ccp_pkg::HREG_PCM:    rdata_d = {16'h0000, cap_q, pcm_out_q};
				default:              rdata_d = 32'h0000_0000;
			endcase
		end
		if (take && avs_write_i && avs_address_i == ccp_pkg::HREG_PCM)
			pcm_out_d = avs_writedata_i[7:0];
		case (st_q)
			H_IDLE:
			begin
				div_d = 8'h00;
				// A command while busy is dropped
				if (take && avs_write_i && avs_address_i == ccp_pkg::HREG_CMD)
				begin
					tx_d   = {avs_writedata_i[7:0], avs_writedata_i[15:8]};
					left_d = avs_writedata_i[ccp_pkg::B1_TWO] ? 5'd16 : 5'd8;
					cs_n_d = 1'b0;
					st_d   = H_LO;
				end
			end
			H_HI:
				if (tick)
				begin
					div_d  = 8'h00;
					control_clock_d = 1'b0;
					rx_d   = {rx_q[6:0], co_s};
					tx_d   = {tx_q[14:0], 1'b0};
					left_d = left_q - 5'd1;
					st_d   = H_LO;
				end
			H_LO:
				if (tick)
				begin
					div_d = 8'h00;
					if (left_q == 5'd0)
					begin
						cs_n_d = 1'b1;
						st_d   = H_END;
					end
					else
					begin
						control_clock_d = 1'b1;
						ci_d   = tx_q[15];
						st_d   = H_HI;
					end
				end
			default:
				if (tick)
					st_d = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			st_q      <= H_IDLE;
			div_q     <= 8'h00;
			rx_q      <= 8'h00;
			tx_q      <= 16'h0000;
			left_q    <= 5'd0;
			cs_n_q    <= 1'b1;
			control_clock_q    <= 1'b0;
			ci_q      <= 1'b0;
			wreq_q    <= 1'b1;
			rdata_q   <= 32'h0000_0000;
			pcm_out_q <= 8'h00;
		end
		else
		begin
			st_q      <= st_d;
			div_q     <= div_d;
			rx_q      <= rx_d;
			tx_q      <= tx_d;
			left_q    <= left_d;
			cs_n_q    <= cs_n_d;
			control_clock_q    <= control_clock_d;
			ci_q      <= ci_d;
			wreq_q    <= wreq_d;
			rdata_q   <= rdata_d;
			pcm_out_q <= pcm_out_d;
		end
	end

	// PCM bus master: bit clock, frame sync on slot 0, one byte out and in per frame
	logic [7:0]    bdiv_q, bdiv_d, cap_sh_q, cap_sh_d, cap_d;
	logic [IW-1:0] idx_q, idx_d;
	logic          bclk_q, bclk_d, fs_q, fs_d, rxin_q, rxin_d;

	always_comb
	begin
		bdiv_d   = bdiv_q + 8'h01;
		bclk_d   = bclk_q;
		idx_d    = idx_q;
		fs_d     = fs_q;
		rxin_d   = rxin_q;
		cap_sh_d = cap_sh_q;
		cap_d    = cap_q;
		if (bdiv_q == 8'(BCLK_HALF - 1))
		begin
			bdiv_d = 8'h00;
			bclk_d = ~bclk_q;
			if (!bclk_q)
			begin
				idx_d  = (idx_q == IW'(FRAME_BITS - 1)) ? '0 : idx_q + IW'(1);
				fs_d   = idx_d == '0;
				rxin_d = (idx_d < IW'(ccp_pkg::BYTE_BITS)) ? pcm_out_q[~idx_d[2:0]] : 1'b0;
			end
			else if (idx_q < IW'(ccp_pkg::BYTE_BITS))
			begin
				cap_sh_d = {cap_sh_q[6:0], dx_s};
				if (idx_q == IW'(ccp_pkg::BYTE_BITS - 1))
					cap_d = cap_sh_d;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			bdiv_q   <= 8'h00;
			bclk_q   <= 1'b0;
			idx_q    <= IW'(FRAME_BITS - 1);
			fs_q     <= 1'b0;
			rxin_q   <= 1'b0;
			cap_sh_q <= 8'h00;
			cap_q    <= 8'h00;
		end
		else
		begin
			bdiv_q   <= bdiv_d;
			bclk_q   <= bclk_d;
			idx_q    <= idx_d;
			fs_q     <= fs_d;
			rxin_q   <= rxin_d;
			cap_sh_q <= cap_sh_d;
			cap_q    <= cap_d;
		end
	end

	assign bus.control_clock   = control_clock_q;
	assign bus.chip_select_n   = cs_n_q;
	assign bus.control_data_in = ci_q;
	assign bus.bit_clock       = bclk_q;
	assign bus.frame_sync_tx   = fs_q;
	assign bus.frame_sync_rx   = fs_q;
	assign bus.pcm_rx_in       = rxin_q;
	assign avs_readdata_o      = rdata_q;
	assign avs_waitrequest_o   = wreq_q;
endmodule

// *** verif/ccp_properties.sv ***
`timescale 1ns/1ps
module ccp_properties #(
	parameter int CONTROL_CLOCK_HALF = ccp_pkg::CONTROL_CLOCK_HALF,
	parameter int BCLK_HALF = ccp_pkg::BCLK_HALF
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic control_clock,
	input wire logic chip_select_n,
	input wire logic control_data_in,
	input wire logic control_data_out,
	input wire logic control_data_out_oe_n,
	input wire logic bit_clock,
	input wire logic pcm_tx_out,
	input wire logic pcm_tx_oe_n,
	input wire logic pcm_rx_in
);
	logic [7:0] cc_age_q, cc_age_d, bc_age_q, bc_age_d;
	logic [4:0] cc_bits_q, cc_bits_d;
	logic [3:0] tx_rises_q, tx_rises_d;
	logic       cc_prev_q, bc_prev_q, cc_rise, bc_rise;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// Ages saturate so a long idle never wraps into a false recent edge
	always_comb
	begin
		cc_rise = control_clock && !cc_prev_q;
		bc_rise = bit_clock && !bc_prev_q;
		cc_age_d = cc_rise ? 8'h00 : cc_age_q + {7'h0, cc_age_q != 8'hff};
		bc_age_d = bc_rise ? 8'h00 : bc_age_q + {7'h0, bc_age_q != 8'hff};
		cc_bits_d = chip_select_n ? 5'h00 : cc_bits_q + {4'h0, cc_rise};
		tx_rises_d = pcm_tx_oe_n ? 4'h0 : tx_rises_q + {3'h0, bc_rise && tx_rises_q != 4'hf};
	end

	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			{cc_age_q, bc_age_q, cc_bits_q, tx_rises_q, cc_prev_q, bc_prev_q} <= '0;
		end
		else
		begin
			{cc_age_q, bc_age_q, cc_bits_q, tx_rises_q} <= {cc_age_d, bc_age_d, cc_bits_d, tx_rises_d};
			{cc_prev_q, bc_prev_q} <= {control_clock, bit_clock};
		end
	end

	cdo_release_a: assert property (chip_select_n [*6] |-> control_data_out_oe_n)
		else $error("control data out driven with select high");
	reset_idle_a: assert property ($rose(reset_n_i) |-> control_data_out_oe_n && pcm_tx_oe_n)
		else $error("outputs driven after reset");
	cdo_drive_a: assert property ($fell(control_data_out_oe_n) |-> control_clock && cc_age_q < CONTROL_CLOCK_HALF)
		else $error("readback drive not after a rising control clock");
	cdo_edge_a: assert property (!control_data_out_oe_n && $changed(control_data_out) |-> cc_age_q < CONTROL_CLOCK_HALF)
		else $error("readback bit changed away from rising edge");
	tx_edge_a: assert property (!pcm_tx_oe_n && $changed(pcm_tx_out) |-> bc_age_q < BCLK_HALF)
		else $error("pcm bit changed away from rising bit clock");
	tx_slot_a: assert property (!pcm_tx_oe_n |-> tx_rises_q <= 4'd8)
		else $error("pcm output driven beyond eight bits");
	tx_start_a: assert property ($fell(pcm_tx_oe_n) |-> bit_clock && bc_age_q < BCLK_HALF)
		else $error("pcm drive not after a rising bit clock");
	control_clock_framed_a: assert property ($rose(control_clock) |-> !chip_select_n)
		else $error("control clock pulsed without select");
	control_clock_high_a: assert property ($rose(control_clock) |-> control_clock [*8] ##1 !control_clock)
		else $error("control clock high phase wrong");
	ci_stable_a: assert property (control_clock && $past(control_clock) |-> $stable(control_data_in))
		else $error("control data in moved while clock high");
	byte_whole_a: assert property ($rose(chip_select_n) |-> cc_bits_q[2:0] == 3'h0)
		else $error("select frame not whole bytes");
	rx_stable_a: assert property (bit_clock && $past(bit_clock) |-> $stable(pcm_rx_in))
		else $error("pcm receive data moved while bit clock high");
endmodule

// *** verif/tb_codec_control_port.sv ***
`timescale 1ns/1ps
module tb_codec_control_port;
	logic        clk_i, reset_n_i, av_rd, av_wr, av_wait, enc, pd, law, dly, cc_prev, rxv;
	logic [3:0]  av_addr, pins_lvl, pins_drv, pins_out, pins_oe_n;
	logic [31:0] av_wd, av_q, q, rnd;
	logic [7:0]  tx_pcm, rx_pcm, rxg, txg, rxg2, mon_b1, rd, wv;
	logic [7:0]  m_ctrl, m_ldata, m_ldir, m_rxg, m_txg;
	logic        m_pd;
	logic [3:0]  codes [3] = '{4'h4, 4'h5, 4'h0};
	int          mon_n, n, errors, samples_checked, rxv_n;

	ccp_if link();
	ccp_if link2();

	// Latch pins resolve to the device level where it drives, else the far side level
	assign pins_lvl = (~pins_oe_n & pins_out) | (pins_oe_n & pins_drv);

	ccp_device i_ccp_device (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(link.dev), .latch_pins_i(pins_lvl),
		.latch_pins_o(pins_out), .latch_pins_oe_n_o(pins_oe_n), .tx_pcm_i(tx_pcm), .rx_pcm_o(rx_pcm),
		.rx_pcm_valid_o(rxv), .encode_start_o(enc), .power_down_o(pd), .law_sel_o(law), .delayed_timing_o(dly),
		.rx_gain_o(rxg), .tx_gain_o(txg));
	ccp_device i_ccp_device_fault (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(link2.dev), .latch_pins_i(pins_drv),
		.latch_pins_o(), .latch_pins_oe_n_o(), .tx_pcm_i(tx_pcm), .rx_pcm_o(), .rx_pcm_valid_o(),
		.encode_start_o(), .power_down_o(), .law_sel_o(), .delayed_timing_o(), .rx_gain_o(rxg2), .tx_gain_o());
	ccp_host i_ccp_host (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus(link.host), .avs_address_i(av_addr),
		.avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_readdata_o(av_q),
		.avs_waitrequest_o(av_wait));
	ccp_properties i_ccp_properties (.clk_i(clk_i), .reset_n_i(reset_n_i), .control_clock(link.control_clock),
		.chip_select_n(link.chip_select_n), .control_data_in(link.control_data_in),
		.control_data_out(link.control_data_out), .control_data_out_oe_n(link.control_data_out_oe_n),
		.bit_clock(link.bit_clock), .pcm_tx_out(link.pcm_tx_out), .pcm_tx_oe_n(link.pcm_tx_oe_n),
		.pcm_rx_in(link.pcm_rx_in));

	always #2.5 clk_i = ~clk_i;

	// First byte as seen on the wire, sampled at falling control clock
	always @(posedge clk_i)
	begin
		cc_prev <= link.control_clock;
		if (rxv)
			rxv_n <= rxv_n + 1;
		if (cc_prev && !link.control_clock && !link.chip_select_n && mon_n < 8)
		begin
			mon_b1 <= {mon_b1[6:0], link.control_data_in};
			mon_n <= mon_n + 1;
		end
		if (link.chip_select_n)
			mon_n <= 0;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		{av_addr, av_wr, av_rd, av_wd} <= {a, wr, !wr, d};
		@(posedge clk_i);
		while (av_wait !== 1'b0 && k < 100)
		begin
			k++;
			@(posedge clk_i);
		end
		if (k == 100)
			errors++;
		r = av_q;
		{av_wr, av_rd} <= 2'b00;
	endtask

	task automatic cmp_all();
		check(16'(pd), 16'(m_pd));
		check({rxg, txg}, {m_rxg, m_txg});
		check({law, dly}, {m_ctrl[ccp_pkg::CTRL_LAW], m_ctrl[ccp_pkg::CTRL_DELAY]});
		check(16'(pins_oe_n), (m_ldir == 8'hff) ? 16'h0 : 16'hf);
		if (m_ldir == 8'hff)
			check(16'(pins_out), 16'(m_ldata[3:0]));
		check({link.chip_select_n, link.control_data_out_line}, 16'h3);
	endtask

	task automatic send(input logic [7:0] b1, input logic [7:0] b2, output logic [7:0] r);
		logic [31:0] s;
		int          k;
		k = 0;
		av(1'b1, ccp_pkg::HREG_CMD, {16'h0, b2, b1}, s);
		s = 32'h1;
		while (s[0] !== 1'b0 && k < 200)
		begin
			av(1'b0, ccp_pkg::HREG_STATUS, 32'h0, s);
			k++;
		end
		if (k == 200)
			errors++;
		r = s[15:8];
		// Every byte 1 latches the sensed levels of the input pins
		m_ldata[3:0] = (m_ldata[3:0] & m_ldir[3:0]) | (pins_drv & ~m_ldir[3:0]);
		if (!b1[1])
			m_pd = b1[7];
		else if (b1[6:3] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5})
		begin
			m_pd = b1[7];
			if (!b1[2])
				case (b1[6:3])
					4'h0: m_ctrl = b2;
					4'h1: m_ldata = b2;
					4'h2: m_ldir = b2;
					4'h4: m_rxg = b2;
					default: m_txg = b2;
				endcase
		end
		check(16'(mon_b1), 16'(b1));
		cmp_all();
	endtask

	task automatic wait_enc();
		int k;
		k = 0;
		@(posedge clk_i);
		while (enc !== 1'b1 && k < 2000)
		begin
			k++;
			@(posedge clk_i);
		end
		if (k == 2000)
			errors++;
		check(16'(link.pcm_tx_oe_n), 16'h1);
	endtask

	// Host stand-in on the second link that can abandon a byte part way
	task automatic raw(input logic [15:0] bits, input int cnt);
		link2.chip_select_n <= 1'b0;
		for (int i = 0; i < cnt; i++)
		begin
			repeat (8) @(posedge clk_i);
			{link2.control_data_in, link2.control_clock} <= {bits[15 - i], 1'b1};
			repeat (8) @(posedge clk_i);
			link2.control_clock <= 1'b0;
		end
		repeat (8) @(posedge clk_i);
		link2.chip_select_n <= 1'b1;
		repeat (24) @(posedge clk_i);
	endtask

	initial
	begin
		{clk_i, reset_n_i, av_rd, av_wr, av_addr, av_wd, tx_pcm, cc_prev, mon_b1} = '0;
		{mon_n, errors, samples_checked, rxv_n} = '0;
		pins_drv = 4'h5;
		{link2.chip_select_n, link2.control_clock, link2.control_data_in} = 3'b100;
		{link2.bit_clock, link2.frame_sync_tx, link2.frame_sync_rx, link2.pcm_rx_in} = 4'h0;
		{m_ctrl, m_ldata, m_ldir, m_rxg, m_txg, m_pd} = {ccp_pkg::CTRL_RST, 16'h0, ccp_pkg::GAIN_RST,
			ccp_pkg::GAIN_RST, ccp_pkg::POWER_DOWN};
		void'($urandom(32'h6a18));
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		cmp_all();
		check(16'(link.pcm_tx_line), 16'h1);
		av(1'b0, 4'hc, 32'h0, q);
		check(q[15:0], 16'h0);
		for (int i = 0; i < 3; i++)
		begin
			rnd = $urandom;
			wv = rnd[7:0] & 8'hf7;
			send({1'b1, codes[i], 3'b010}, wv, rd);
			send({1'b1, codes[i], 3'b110}, 8'h00, rd);
			check(16'(rd), 16'(wv));
		end
		send(8'h92, 8'hff, rd);
		send(8'h8a, 8'hff, rd);
		send(8'h8a, 8'h00, rd);
		send(8'h92, 8'h00, rd);
		send(8'h00, 8'h00, rd);
		send(8'hfa, 8'h3c, rd);
		for (int i = 0; i < 2; i++)
		begin
			rnd = $urandom;
			tx_pcm <= rnd[7:0];
			pins_drv <= rnd[19:16];
			av(1'b1, ccp_pkg::HREG_PCM, {24'h0, rnd[15:8]}, q);
			wait_enc();
			n = rxv_n;
			wait_enc();
			check(16'(rxv_n - n), 16'h1);
			repeat (40) @(posedge clk_i);
			av(1'b0, ccp_pkg::HREG_PCM, 32'h0, q);
			check(q[15:0], {rnd[7:0], rnd[15:8]});
			check(16'(rx_pcm), 16'(rnd[15:8]));
		end
		send(8'ha2, 8'h3c, rd);
		n = 0;
		repeat (1200)
		begin
			@(posedge clk_i);
			if (link.pcm_tx_oe_n !== 1'b1)
				n++;
		end
		check(16'(n), 16'h0);
		raw({8'h22, 8'h00}, 3);
		raw({8'h22, 8'h77}, 12);
		check(16'(rxg2), 16'h0);
		raw({8'h22, 8'h5a}, 16);
		check(16'(rxg2), 16'h5a);
		end_of_test();
	end

	// Whole run needs roughly eight thousand cycles
	initial
	begin
		repeat (40000) @(posedge clk_i);
		errors++;
		end_of_test();
	end
endmodule
